// *** verilog/spgc_consts.svh ***
// Constants for the serial-lane pattern generator and checker block.
`ifndef SPGC_CONSTS_SVH
`define SPGC_CONSTS_SVH
`define SPGC_OFF_GEN 12'h00c
`define SPGC_OFF_PM 12'h02c
`define SPGC_OFF_SS 12'h030
`define SPGC_OFF_FI 12'h034
`define SPGC_GEN_RESET 32'h0000_0000
`define SPGC_FI_RESET 32'h0000_0000
`define SPGC_GEN_MODE_HI 18
`define SPGC_GEN_MODE_LO 16
`define SPGC_GEN_ERR_BIT 19
`define SPGC_GEN_WORD_HI 29
`define SPGC_GEN_WORD_LO 20
`define SPGC_PM_MODE_HI 2
`define SPGC_PM_MODE_LO 0
`define SPGC_PM_LOCK_BIT 3
`define SPGC_PM_CNT_LO 16
`define SPGC_PM_SCALE_BIT 31
`define SPGC_SS_PH_LO 17
`define SPGC_SS_FRAC_BIT 16
`define SPGC_SS_SCALE_BIT 15
`define SPGC_FI_OFS_LO 1
`define SPGC_CNT_MAX 15'h7fff
`define SPGC_PRESCALE_MAX 7'h7f
`define SPGC_WORD_ONES 10'h3ff
`define SPGC_WORD_ZERO 10'h000
`define SPGC_BIT_AGO 10
`endif

// *** verilog/spgc_pkg.sv ***
// Types shared by the pattern generator and checker block.
`default_nettype none
package spgc_pkg;
    typedef enum logic [2:0] {
        SPGC_GEN_OFF,
        SPGC_GEN_LFSR15,
        SPGC_GEN_LFSR7,
        SPGC_GEN_FIXED,
        SPGC_GEN_DCBAL,
        SPGC_GEN_QUAD
    } spgc_gen_mode_t;
    typedef enum logic [2:0] {
        SPGC_PM_OFF,
        SPGC_PM_LFSR15,
        SPGC_PM_LFSR7,
        SPGC_PM_REPEAT,
        SPGC_PM_INVERT
    } spgc_pm_mode_t;
    typedef struct packed {
        logic valid;
        logic data;
    } spgc_bit_t;
    typedef struct packed {
        logic [10:0] phase_selector_value;
        logic phase_fraction;
        logic [12:0] freq_offset;
        logic freq_fraction;
    } spgc_loop_t;
endpackage
`default_nettype wire

// *** verilog/spgc_err_counter.sv ***
// Scaled 15-bit error counter with saturation and pipelined clear-on-second-read.
`default_nettype none
module spgc_err_counter
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Events.
    input wire logic err,
    input wire logic rd_strobe,
    // Captured value.
    output logic scale,
    output logic [14:0] count,
    output logic second_read
);
`include "spgc_consts.svh"
    logic [6:0] prescale;
    logic read_armed;
    wire clear_now = rd_strobe && read_armed;
    wire saturated = scale && (count == `SPGC_CNT_MAX);
    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    // After the first overflow the count switches to units of 128 errors.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= '0;
            scale <= 1'b0;
            prescale <= '0;
        end
        else if (clear_now)
        begin
            count <= '0;
            scale <= 1'b0;
            prescale <= '0;
        end
        else if (err && !saturated)
        begin
            if (!scale && count == `SPGC_CNT_MAX)
            begin
                scale <= 1'b1;
                count <= 15'h00ff;
                prescale <= '0;
            end
            else if (!scale)
                count <= count + 15'h0001;
            else if (prescale == `SPGC_PRESCALE_MAX)
            begin
                prescale <= '0;
                count <= count + 15'h0001;
            end
            else
                prescale <= prescale + 7'h01;
        end
    end
    // Alternating reads: the first arms, the second clears.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            read_armed <= 1'b0;
        else if (rd_strobe)
            read_armed <= !read_armed;
    end
    assign second_read = clear_now;

    property p_sat_hold;
        @(posedge pclk) disable iff (!presetn) saturated && !rd_strobe |=> saturated;
    endproperty
    a_sat_hold: assert property (p_sat_hold) else $error("saturated counter moved");
    property p_clear;
        @(posedge pclk) disable iff (!presetn) clear_now |=> (count == 15'h0000) && !scale;
    endproperty
    a_clear: assert property (p_clear) else $error("second read did not clear");
endmodule
`default_nettype wire

// *** verilog/spgc_top.sv ***
// Pattern generator, pattern matcher and loop readback registers on APB.
// Contract
// - Mode 1 emits 15-bit LFSR x^15+x^14+1; mode 0 disables.
// - Mode 2 emits 7-bit LFSR x^7+x^6+1.
// - Mode 3 repeats the word; mode 4 alternates word and inverse.
// - Mode 5 cycles zeros, word, ones, inverse word.
// - Ten-bit generator word at bits 29:20.
// - Bit 19 corrupts exactly one output bit.
// - Generator control register resets to zero.
// - Matcher mode 2:0 selects LFSR15, LFSR7, repeat or inverse-repeat check.
// - Fifteen-bit error count at 30:16; scale flag means units of 128.
// - Scale flag with full count signals overflow.
// - Second counter: scale at bit 15, count at 14:0.
// - Counter reads are pipelined; two reads give the current value.
// - Second read of a counter register clears it.
// - Counters update at any time regardless of software; an error in the same cycle as a clearing second read is not counted.
// - Phase selector value readable at bits 27:17.
// - Phase fraction bit at 16.
// - Frequency offset at bits 13:1, 1.526 ppm per step.
// - Frequency offset is two's complement.
// - Bit 0 carries frequency fraction.
//
// Implementation choice: the APB interface to the registers.
`default_nettype none
module spgc_top
    import spgc_pkg::*;
(
    // APB slave.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial data path.
    output var spgc_pkg::spgc_bit_t tx_bit,
    input wire logic rx_data_in,
    input wire logic ss_err_in,
    // Clock recovery loop state.
    input wire spgc_pkg::spgc_loop_t loop_in
);
    import spgc_pkg::*;
`include "spgc_consts.svh"
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [14:0] lfsr_step(input logic [14:0] s, input logic wide);
        logic fb;
        fb = wide ? (s[14] ^ s[13]) : (s[6] ^ s[5]);
        lfsr_step = wide ? {s[13:0], fb} : {8'h00, s[5:0], fb};
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic rx_m, rx_s, sse_m, sse_s;
    spgc_loop_t loop_m, loop_s;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_m <= 1'b0;
            rx_s <= 1'b0;
            sse_m <= 1'b0;
            sse_s <= 1'b0;
            loop_m <= '0;
            loop_s <= '0;
        end
        else
        begin
            rx_m <= rx_data_in;
            rx_s <= rx_m;
            sse_m <= ss_err_in;
            sse_s <= sse_m;
            loop_m <= loop_in;
            loop_s <= loop_m;
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic [31:0] gen_ctl;
    logic [3:0] pm_ctl;
    spgc_loop_t loop_snap;
    logic inj_done;
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit_gen = paddr == `SPGC_OFF_GEN;
    wire hit_pm = paddr == `SPGC_OFF_PM;
    wire hit_ss = paddr == `SPGC_OFF_SS;
    wire hit_fi = paddr == `SPGC_OFF_FI;
    wire hit_any = hit_gen || hit_pm || hit_ss || hit_fi;
    wire [2:0] gen_mode = gen_ctl[`SPGC_GEN_MODE_HI:`SPGC_GEN_MODE_LO];
    wire [9:0] gen_word = gen_ctl[`SPGC_GEN_WORD_HI:`SPGC_GEN_WORD_LO];
    wire [2:0] pm_mode = pm_ctl[`SPGC_PM_MODE_HI:`SPGC_PM_MODE_LO];
    wire pm_lock = pm_ctl[`SPGC_PM_LOCK_BIT];

    // Writable bits only; reserved bits stay zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gen_ctl <= `SPGC_GEN_RESET;
            pm_ctl <= '0;
        end
        else if (wr && hit_gen)
            gen_ctl <= {2'b00, pwdata[29:16], 16'h0000};
        else if (wr && hit_pm)
            pm_ctl <= pwdata[3:0];
        else if (gen_ctl[`SPGC_GEN_ERR_BIT] && inj_done)
            gen_ctl[`SPGC_GEN_ERR_BIT] <= 1'b0;
    end

    // ------------------------------------------------------------
    // Pattern generator
    // ------------------------------------------------------------
    logic [14:0] gen_lfsr;
    logic [3:0] gen_pos;
    logic [1:0] gen_word_idx;
    wire gen_on = gen_mode >= 3'd1 && gen_mode <= 3'd5;
    wire gen_lfsr_mode = gen_mode == SPGC_GEN_LFSR15 || gen_mode == SPGC_GEN_LFSR7;
    logic [9:0] cur_word;
    always_comb
    begin
        cur_word = gen_word;
        if (gen_mode == SPGC_GEN_DCBAL && gen_word_idx[0])
            cur_word = ~gen_word;
        else if (gen_mode == SPGC_GEN_QUAD)
        begin
            case (gen_word_idx)
                2'd0: cur_word = `SPGC_WORD_ZERO;
                2'd1: cur_word = gen_word;
                2'd2: cur_word = `SPGC_WORD_ONES;
                default: cur_word = ~gen_word;
            endcase
        end
    end
    wire raw_bit = gen_lfsr_mode ? gen_lfsr[gen_mode == SPGC_GEN_LFSR15 ? 14 : 6] : cur_word[gen_pos];
    wire inject = gen_ctl[`SPGC_GEN_ERR_BIT] && !inj_done && gen_on && (gen_lfsr_mode || gen_pos == 4'd0);
    wire [14:0] lfsr_seed = 15'h7fff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gen_lfsr <= 15'h7fff;
            gen_pos <= '0;
            gen_word_idx <= '0;
            inj_done <= 1'b0;
            tx_bit <= '0;
        end
        else
        begin
            tx_bit.valid <= gen_on;
            tx_bit.data <= gen_on ? raw_bit ^ inject : 1'b0;
            if (!gen_ctl[`SPGC_GEN_ERR_BIT])
                inj_done <= 1'b0;
            else if (inject)
                inj_done <= 1'b1;
            if (!gen_on)
            begin
                gen_lfsr <= lfsr_seed;
                gen_pos <= '0;
                gen_word_idx <= '0;
            end
            else if (gen_lfsr_mode)
                gen_lfsr <= lfsr_step(gen_lfsr, gen_mode == SPGC_GEN_LFSR15);
            else if (gen_pos == 4'd9)
            begin
                gen_pos <= '0;
                gen_word_idx <= gen_word_idx + 2'd1;
            end
            else
                gen_pos <= gen_pos + 4'd1;
        end
    end

    // ------------------------------------------------------------
    // Pattern matcher
    // ------------------------------------------------------------
    logic [14:0] pm_lfsr;
    logic [9:0] pm_hist;
    logic lock_seen;
    logic pm_armed;
    wire pm_on = pm_mode >= 3'd1 && pm_mode <= 3'd4;
    wire pm_lfsr_mode = pm_mode == SPGC_PM_LFSR15 || pm_mode == SPGC_PM_LFSR7;
    wire [14:0] pm_next = lfsr_step(pm_lfsr, pm_mode == SPGC_PM_LFSR15);
    logic pm_expect;
    always_comb
    begin
        case (pm_mode)
            SPGC_PM_LFSR15: pm_expect = pm_next[0];
            SPGC_PM_LFSR7: pm_expect = pm_next[0];
            SPGC_PM_REPEAT: pm_expect = pm_hist[`SPGC_BIT_AGO - 1];
            SPGC_PM_INVERT: pm_expect = !pm_hist[`SPGC_BIT_AGO - 1];
            default: pm_expect = rx_s;
        endcase
    end
    wire pm_err = pm_on && pm_armed && !pm_lock && (pm_expect != rx_s);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pm_lfsr <= '0;
            pm_hist <= '0;
            lock_seen <= 1'b0;
            pm_armed <= 1'b0;
        end
        else
        begin
            pm_hist <= {pm_hist[8:0], rx_s};
            if (pm_lock)
                pm_lfsr <= pm_lfsr_mode ? {pm_lfsr[13:0], rx_s} : pm_lfsr;
            else if (pm_lfsr_mode)
                pm_lfsr <= pm_next;
            if (!pm_on)
                lock_seen <= 1'b0;
            else if (pm_lock)
                lock_seen <= 1'b1;
            pm_armed <= pm_on && !pm_lock && (lock_seen || pm_armed);
        end
    end

    // ------------------------------------------------------------
    // Error counters
    // ------------------------------------------------------------
    logic pm_scale, ss_scale;
    logic [14:0] pm_count, ss_count;
    spgc_err_counter u_pm_cnt
    (
        .pclk(pclk),
        .presetn(presetn),
        .err(pm_err),
        .rd_strobe(rd && hit_pm),
        .scale(pm_scale),
        .count(pm_count),
        .second_read()
    );
    spgc_err_counter u_ss_cnt
    (
        .pclk(pclk),
        .presetn(presetn),
        .err(sse_s),
        .rd_strobe(rd && hit_ss),
        .scale(ss_scale),
        .count(ss_count),
        .second_read()
    );
    // Pipelined read stage: each read returns the snapshot of the previous one.
    logic [15:0] pm_pipe, ss_pipe;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pm_pipe <= '0;
            ss_pipe <= '0;
            loop_snap <= '0;
        end
        else
        begin
            if (rd && hit_pm)
                pm_pipe <= {pm_scale, pm_count};
            if (rd && hit_ss)
                ss_pipe <= {ss_scale, ss_count};
            if (rd && (hit_ss || hit_fi))
                loop_snap <= loop_s;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [31:0] rd_word;
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (hit_gen)
            rd_word = gen_ctl;
        else if (hit_pm)
            rd_word = {pm_pipe, 12'h000, pm_ctl};
        else if (hit_ss)
            rd_word = {4'h0, loop_snap.phase_selector_value, loop_snap.phase_fraction, ss_pipe};
        else if (hit_fi)
            rd_word = {18'h00000, loop_snap.freq_offset, loop_snap.freq_fraction};
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            if (psel && !penable && !pwrite)
                prdata <= rd_word;
        end
    end

    property p_gen_off;
        @(posedge pclk) disable iff (!presetn) !gen_on |=> !tx_bit.valid && !tx_bit.data;
    endproperty
    a_gen_off: assert property (p_gen_off) else $error("generator active while disabled");
    property p_reset_gen;
        @(posedge pclk) $rose(presetn) |-> gen_ctl == `SPGC_GEN_RESET;
    endproperty
    a_reset_gen: assert property (p_reset_gen) else $error("control not zero after reset");
    property p_fixed;
        @(posedge pclk) disable iff (!presetn)
            gen_mode == SPGC_GEN_FIXED && !inject && $stable(gen_ctl) |=> tx_bit.data == $past(gen_word[gen_pos]);
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed word bit wrong");
    sequence s_lock_on_off;
        pm_lock ##1 !pm_lock;
    endsequence
    property p_no_check_before_lock;
        @(posedge pclk) disable iff (!presetn)
            !pm_armed && !(rd && hit_pm) |=> $stable(pm_count) && $stable(pm_scale);
    endproperty
    a_no_check_before_lock: assert property (p_no_check_before_lock) else $error("checked before lock");
    property p_arm_after_lock;
        @(posedge pclk) disable iff (!presetn) pm_on ##0 s_lock_on_off ##0 pm_on |=> pm_armed;
    endproperty
    a_arm_after_lock: assert property (p_arm_after_lock) else $error("matcher not armed");
    property p_inject_once;
        @(posedge pclk) disable iff (!presetn) inject |=> !inject;
    endproperty
    a_inject_once: assert property (p_inject_once) else $error("more than one error injected");
    property p_pready;
        @(posedge pclk) disable iff (!presetn) psel && !penable |=> pready;
    endproperty
    a_pready: assert property (p_pready) else $error("no ready after setup");
    property p_pm_off;
        @(posedge pclk) disable iff (!presetn)
            !pm_on && !(rd && hit_pm) |=> $stable(pm_count) && $stable(pm_scale);
    endproperty
    a_pm_off: assert property (p_pm_off) else $error("matcher counted while off");
endmodule
`default_nettype wire

// *** testbench/spgc_partner.sv ***
// Loopback model of the far-side serial path and the clock-recovery loop state.
`default_nettype none
module spgc_partner
    import spgc_pkg::*;
#(
    parameter logic [10:0] PHASE = 11'h5a3,
    parameter logic [12:0] FREQ = 13'h1f38
)
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Serial path.
    input wire spgc_pkg::spgc_bit_t tx_bit,
    input wire logic flip,
    output logic rx_data_in,
    // Loop state.
    output var spgc_pkg::spgc_loop_t loop_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // -------------------------------------------------------------
    // Serial return path
    // -------------------------------------------------------------
    // An idle transmitter leaves the line toggling, so a checker cannot lean on a stale level.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_data_in <= 1'b0;
        else if (tx_bit.valid)
            rx_data_in <= tx_bit.data ^ flip;
        else
            rx_data_in <= ~rx_data_in;
    end
    assign loop_in = '{phase_selector_value: PHASE, phase_fraction: 1'b1, freq_offset: FREQ, freq_fraction: 1'b1};
endmodule
`default_nettype wire

// *** testbench/spgc_top_bench.sv ***
// Self-checking bench for the pattern generator and checker block.
`default_nettype none
`include "spgc_consts.svh"
module spgc_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import spgc_pkg::*;
    localparam logic [10:0] PH = 11'h5a3;
    localparam logic [12:0] FO = 13'h1f38;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    spgc_bit_t tx_bit;
    logic rx_data_in;
    logic ss_err_in = 1'b0;
    logic flip = 1'b0;
    spgc_loop_t loop_in;
    logic [1:0] hist [0:1023];
    int hp = 0;
    int n_fail = 0;
    int num_checks = 0;
    logic [31:0] q;
    logic err;
    // Matcher scenarios: generator mode, matcher mode, injected line flips, expected error count.
    int tab [5][4] = '{'{1, 1, 0, 0}, '{2, 2, 0, 0}, '{3, 3, 3, 6}, '{4, 4, 2, 4}, '{4, 5, 2, 0}};
    always #25 pclk = ~pclk;
    spgc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_bit(tx_bit), .rx_data_in(rx_data_in), .ss_err_in(ss_err_in), .loop_in(loop_in));
    spgc_partner #(.PHASE(PH), .FREQ(FO)) i_far (.pclk(pclk), .presetn(presetn), .tx_bit(tx_bit),
        .flip(flip), .rx_data_in(rx_data_in), .loop_in(loop_in));
    // -------------------------------------------------------------
    // Output stream history
    // -------------------------------------------------------------
    always @(posedge pclk)
    begin
        hist[hp % 1024] = tx_bit;
        hp = hp + 1;
    end
    // -------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------
    task automatic wrap_up();
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            n_fail++;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20)
        begin
            n_fail++;
            wrap_up();
        end
    endtask
    task automatic rd2(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Returns 1 where a recorded bit breaks the relation of the given generator mode.
    function automatic logic bad(input int k, input int m);
        logic [1:0] h;
        h = hist[k % 1024];
        case (m)
            1: bad = h[0] ^ hist[(k - 14) % 1024][0] ^ hist[(k - 15) % 1024][0];
            2: bad = h[0] ^ hist[(k - 6) % 1024][0] ^ hist[(k - 7) % 1024][0];
            3: bad = h[0] ^ hist[(k - 10) % 1024][0];
            4: bad = ~(h[0] ^ hist[(k - 10) % 1024][0]);
            5: bad = h[0] ^ hist[(k - 40) % 1024][0];
            default: bad = |h;
        endcase
        if (m >= 1 && h[1] !== 1'b1)
            bad = 1'b1;
    endfunction
    task automatic stream(input string nm, input int m, input int exp);
        int k;
        int n;
        n = 0;
        for (k = hp - 60; k < hp; k++)
            n += (bad(k, m) !== 1'b0);
        chk(nm, n, exp);
    endtask
    function automatic int ones(input int len);
        int k;
        ones = 0;
        for (k = hp - len; k < hp; k++)
            ones += hist[k % 1024][0];
    endfunction
    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial
    begin
        int m;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SPGC_OFF_GEN, 32'h0);
        chk("gen reset", q, `SPGC_GEN_RESET);
        apb(1'b0, `SPGC_OFF_FI, 32'h0);
        chk("freq reset", q, `SPGC_FI_RESET);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped err", err, 1'b1);
        chk("unmapped data", q, 32'h0);
        for (m = 0; m < 8; m++)
        begin
            apb(1'b1, `SPGC_OFF_GEN, {12'h2d6, 1'b0, m[2:0], 16'h0000});
            idle(110);
            stream("gen stream", (m > 5) ? 0 : m, 0);
            if (m == 3)
                chk("fixed ones", ones(10), 6);
            if (m == 5)
                chk("quad ones", ones(40), 20);
        end
        apb(1'b1, `SPGC_OFF_GEN, 32'hed67_7fff);
        apb(1'b0, `SPGC_OFF_GEN, 32'h0);
        chk("gen readback", q, 32'h2d67_0000);
        apb(1'b1, `SPGC_OFF_GEN, 32'h2d63_0000);
        idle(30);
        apb(1'b1, `SPGC_OFF_GEN, 32'h2d6b_0000);
        idle(40);
        stream("inject", 3, 2);
        apb(1'b0, `SPGC_OFF_GEN, 32'h0);
        chk("inject clears", q, 32'h2d63_0000);
        for (m = 0; m < 5; m++)
        begin
            apb(1'b1, `SPGC_OFF_GEN, {12'h2d6, 1'b0, tab[m][0][2:0], 16'h0000});
            apb(1'b1, `SPGC_OFF_PM, {28'h0, 1'b1, tab[m][1][2:0]});
            idle(30);
            apb(1'b1, `SPGC_OFF_PM, {29'h0, tab[m][1][2:0]});
            idle(30);
            rd2(`SPGC_OFF_PM);
            repeat (tab[m][2])
            begin
                @(posedge pclk);
                flip <= 1'b1;
                @(posedge pclk);
                flip <= 1'b0;
                idle(13);
            end
            idle(40);
            rd2(`SPGC_OFF_PM);
            chk("match count", q, {1'b0, 15'(tab[m][3]), 13'h0, tab[m][1][2:0]});
            rd2(`SPGC_OFF_PM);
            chk("match cleared", q, {29'h0, tab[m][1][2:0]});
        end
        rd2(`SPGC_OFF_SS);
        ss_err_in <= 1'b1;
        idle(100);
        ss_err_in <= 1'b0;
        idle(10);
        rd2(`SPGC_OFF_SS);
        chk("second count", q, {4'h0, PH, 1'b1, 1'b0, 15'd100});
        rd2(`SPGC_OFF_SS);
        chk("second cleared", q[15:0], 16'h0);
        rd2(`SPGC_OFF_FI);
        chk("freq", q, {18'h0, FO, 1'b1});
        chk("freq sign", q[13], 1'b1);
        ss_err_in <= 1'b1;
        idle(33151);
        ss_err_in <= 1'b0;
        idle(10);
        rd2(`SPGC_OFF_SS);
        chk("scaled count", {q[15], q[14:3]}, {1'b1, 12'h020});
        apb(1'b1, `SPGC_OFF_GEN, 32'h2d6b_0000);
        @(posedge pclk);
        presetn <= 1'b0;
        idle(3);
        presetn <= 1'b1;
        apb(1'b0, `SPGC_OFF_GEN, 32'h0);
        chk("gen after reset", q, `SPGC_GEN_RESET);
        wrap_up();
    end
endmodule
`default_nettype wire
